//--- core/iosq_params.svh
// constants for the i/o instruction sequencer
`ifndef IOSQ_PARAMS_SVH
`define IOSQ_PARAMS_SVH
`define IOSQ_OP_BLK_IN     6'h38
`define IOSQ_OP_BLK_OUT    6'h39
`define IOSQ_OP_BUF_IN     6'h3a
`define IOSQ_OP_BUF_OUT    6'h3b
`define IOSQ_OP_WORD_IN    6'h3e
`define IOSQ_OP_IMM_OUT    6'h3c
`define IOSQ_OP_SELECT     6'h3d
`define IOSQ_OP_BUF_CLR    6'h07
`define IOSQ_TAG_LO_BITS   4
`define IOSQ_BLK_MAX_WORDS 255
`define IOSQ_BUF_MAX_WORDS 1024
`define IOSQ_CLK_MHZ       20
`define IOSQ_BUF_START_US  8
`define IOSQ_BUF_START_CYC (`IOSQ_BUF_START_US * `IOSQ_CLK_MHZ)
`define IOSQ_WORD_IN_US    8
`define IOSQ_WORD_IN_CYC   (`IOSQ_WORD_IN_US * `IOSQ_CLK_MHZ)
`define IOSQ_FIFO_DEPTH    4
`define IOSQ_ACC_RST       8'h00
`endif

//--- core/iosq_pkg.sv
// types shared by the i/o instruction sequencer
package iosq_pkg;
  typedef logic [11:0] iosq_addr_t;
  typedef logic [7:0]  iosq_word_t;
  typedef struct packed {
    logic [1:0] tag_sel;
    logic [5:0] opcode;
  } iosq_instr_t;
  typedef struct packed {
    logic       valid;
    logic       is_select;
    iosq_word_t data;
  } iosq_out_t;
  typedef enum logic [3:0] {
    IOSQ_IDLE  = 4'h0,
    IOSQ_FETCH = 4'h1,
    IOSQ_WAIT1 = 4'h2,
    IOSQ_WORD2 = 4'h3,
    IOSQ_WAIT2 = 4'h4,
    IOSQ_WORD3 = 4'h5,
    IOSQ_XFER  = 4'h6,
    IOSQ_MWAIT = 4'h7,
    IOSQ_DELAY = 4'h8,
    IOSQ_WIN   = 4'h9,
    IOSQ_DONE  = 4'ha
  } iosq_state_t;
endpackage

//--- core/iosq_fifo.sv
// small valid/ready fifo on the outgoing word path
`timescale 1ns/1ps
module iosq_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input  wire logic             ref_clk_i,
  input  wire logic             nrst_i,
  input  wire logic             ce_i,
  input  wire logic             clr_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             pop;
  assign in_ready_o  = (cnt_ff != DEPTH[AW:0]);
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o  = mem_ff[rd_ff];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  always_ff @(posedge ref_clk_i) begin
    if (ce_i && push) begin
      mem_ff[wr_ff] <= in_data_i;
    end
  end
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else if (ce_i) begin
      if (clr_i) begin
        wr_ff  <= '0;
        rd_ff  <= '0;
        cnt_ff <= '0;
      end else begin
        if (push) begin
          wr_ff <= AW'(wr_ff + 1'b1);
        end
        if (pop) begin
          rd_ff <= AW'(rd_ff + 1'b1);
        end
        cnt_ff <= (AW+1)'(cnt_ff + push - pop);
      end
    end
  end
endmodule

//--- core/iosq_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module iosq_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk_i,
  input  wire logic             nrst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_ff;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_ff <= '0;
      sync_o  <= '0;
    end else if (ce_i) begin
      meta_ff <= async_i;
      sync_o  <= meta_ff;
    end
  end
endmodule

//--- core/iosq_top.sv
// i/o instruction sequencer: block, buffered and single-word transfers
`timescale 1ns/1ps
`include "iosq_params.svh"
module iosq_top
  import iosq_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       ce_i,
  // execute request from the fetch/execute control
  input  wire logic       exec_start_i,
  input  wire iosq_instr_t exec_instr_i,
  input  wire iosq_addr_t exec_p_i,
  output logic            exec_done_o,
  output iosq_addr_t      next_p_o,
  output logic            acc_we_o,
  output iosq_word_t      acc_o,
  // tag register file lookup
  output logic [1:0]      tag_sel_o,
  input  wire logic [3:0] tag_val_i,
  // memory port
  output logic            mem_req_o,
  output logic            mem_we_o,
  output iosq_addr_t      mem_addr_o,
  output iosq_word_t      mem_wdata_o,
  input  wire logic       mem_ack_i,
  input  wire iosq_word_t mem_rdata_i,
  // buffer channel control
  output logic            buf_in_start_o,
  output logic            buf_out_start_o,
  output logic            buf_clear_o,
  input  wire logic       buf_busy_i,
  // peripheral lines (pins)
  output iosq_word_t      dev_out_data_o,
  output logic            dev_out_sel_o,
  output logic            dev_out_rdy_o,
  input  wire logic       dev_out_ack_i,
  input  wire iosq_word_t dev_in_data_i,
  input  wire logic       dev_in_rdy_i,
  output logic            dev_in_ack_o,
  input  wire logic       dev_disc_i
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [10:0] pin_s;
  iosq_sync #(.WIDTH(11)) u_sync (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .async_i   ({dev_out_ack_i, dev_in_rdy_i, dev_disc_i, dev_in_data_i}),
    .sync_o    (pin_s)
  );
  logic       out_ack_s;
  logic       in_rdy_s;
  logic       disc_s;
  iosq_word_t in_data_s;
  assign {out_ack_s, in_rdy_s, disc_s, in_data_s} = pin_s;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // a boundary address is one whose increment carries into the tag bits
  function automatic logic is_boundary(input iosq_word_t a);
    return (a == 8'hff);
  endfunction
  function automatic iosq_addr_t join_addr(input logic [3:0] t, input iosq_word_t w);
    return {t, w};
  endfunction

  iosq_state_t st_ff;
  iosq_state_t nxt_st;
  iosq_instr_t ins_ff;
  iosq_addr_t  p_ff;
  iosq_word_t  w2_ff;
  iosq_word_t  w3_ff;
  iosq_addr_t  cur_ff;
  logic [15:0] dly_ff;
  logic        word_in_sent_ff;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [9:0]  fifo_out_data;
  logic        fifo_push;
  iosq_out_t   push_word;
  logic        mem_rd_pend_ff;

  wire logic is_blk   = ins_ff.opcode == `IOSQ_OP_BLK_IN || ins_ff.opcode == `IOSQ_OP_BLK_OUT;
  wire logic is_three = is_blk || ins_ff.opcode == `IOSQ_OP_SELECT;
  wire logic is_two   = ins_ff.opcode == `IOSQ_OP_BUF_IN || ins_ff.opcode == `IOSQ_OP_BUF_OUT
                        || ins_ff.opcode == `IOSQ_OP_IMM_OUT;
  wire logic blk_in   = ins_ff.opcode == `IOSQ_OP_BLK_IN;
  wire iosq_addr_t end_addr = join_addr(tag_val_i, w3_ff);

  assign tag_sel_o = (ins_ff.opcode == `IOSQ_OP_WORD_IN ||
                      ins_ff.opcode == `IOSQ_OP_IMM_OUT) ? 2'b00 : ins_ff.tag_sel;

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      IOSQ_IDLE:  if (exec_start_i) nxt_st = IOSQ_FETCH;
      IOSQ_FETCH: begin
        if (is_three || is_two) nxt_st = IOSQ_WAIT1;
        else if (ins_ff.opcode == `IOSQ_OP_WORD_IN) nxt_st = IOSQ_DELAY;
        else nxt_st = IOSQ_DONE;
      end
      IOSQ_WAIT1: if (mem_ack_i) nxt_st = IOSQ_WORD2;
      IOSQ_WORD2: begin
        if (is_three) nxt_st = IOSQ_WAIT2;
        else if (ins_ff.opcode == `IOSQ_OP_IMM_OUT) nxt_st = IOSQ_MWAIT;
        else nxt_st = IOSQ_DELAY;
      end
      IOSQ_WAIT2: if (mem_ack_i) nxt_st = IOSQ_WORD3;
      IOSQ_WORD3: nxt_st = is_blk ? IOSQ_XFER : IOSQ_MWAIT;
      IOSQ_XFER: begin
        if (cur_ff == end_addr) nxt_st = IOSQ_MWAIT;
        else if (blk_in && disc_s) nxt_st = IOSQ_DONE;
      end
      IOSQ_MWAIT: if (!fifo_out_valid && fifo_in_ready && !fifo_push) nxt_st = IOSQ_DONE;
      IOSQ_DELAY: begin
        if (dly_ff == 16'h0001) begin
          nxt_st = (ins_ff.opcode == `IOSQ_OP_WORD_IN) ? IOSQ_WIN : IOSQ_DONE;
        end
      end
      IOSQ_WIN:   if (word_in_sent_ff && !in_rdy_s) nxt_st = IOSQ_DONE;
      IOSQ_DONE:  nxt_st = IOSQ_IDLE;
      default:    nxt_st = IOSQ_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= IOSQ_IDLE;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // instruction capture
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ins_ff <= '0;
      p_ff   <= '0;
      w2_ff  <= '0;
      w3_ff  <= '0;
    end else if (ce_i) begin
      if (st_ff == IOSQ_IDLE && exec_start_i) begin
        ins_ff <= exec_instr_i;
        p_ff   <= exec_p_i;
      end
      if (st_ff == IOSQ_WAIT1 && mem_ack_i) w2_ff <= mem_rdata_i;
      if (st_ff == IOSQ_WAIT2 && mem_ack_i) w3_ff <= mem_rdata_i;
    end
  end

  // ---------------------------------------------------------------
  // block transfer address walk
  // ---------------------------------------------------------------
  wire logic in_take  = st_ff == IOSQ_XFER && blk_in && in_rdy_s && !dev_in_ack_o
                        && cur_ff != end_addr && !mem_req_o
                        && !is_boundary(cur_ff[7:0]);
  wire logic out_load = st_ff == IOSQ_XFER && !blk_in && cur_ff != end_addr
                        && !mem_rd_pend_ff && fifo_in_ready && !is_boundary(cur_ff[7:0]);

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur_ff         <= '0;
      mem_rd_pend_ff <= 1'b0;
    end else if (ce_i) begin
      if (st_ff == IOSQ_WORD3) begin
        cur_ff <= join_addr(tag_val_i, w2_ff);
      end else if (st_ff == IOSQ_XFER && cur_ff != end_addr) begin
        // tag bits are never advanced, so a boundary word is passed over untouched
        if (is_boundary(cur_ff[7:0])) begin
          cur_ff <= {cur_ff[11:8], 8'h00};
        end else if (blk_in && mem_req_o && mem_ack_i) begin
          cur_ff <= iosq_addr_t'(cur_ff + 1'b1);
        end else if (!blk_in && mem_rd_pend_ff && mem_ack_i) begin
          cur_ff <= iosq_addr_t'(cur_ff + 1'b1);
        end
      end
      if (out_load) mem_rd_pend_ff <= 1'b1;
      else if (mem_ack_i) mem_rd_pend_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // memory port
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_req_o   <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_addr_o  <= '0;
      mem_wdata_o <= '0;
    end else if (ce_i) begin
      if (mem_req_o && mem_ack_i) begin
        mem_req_o <= 1'b0;
        mem_we_o  <= 1'b0;
      end else if (st_ff == IOSQ_FETCH && (is_three || is_two)) begin
        mem_req_o  <= 1'b1;
        mem_addr_o <= iosq_addr_t'(p_ff + 1'b1);
      end else if (st_ff == IOSQ_WORD2 && is_three) begin
        mem_req_o  <= 1'b1;
        mem_addr_o <= iosq_addr_t'(p_ff + 2'd2);
      end else if (in_take) begin
        mem_req_o   <= 1'b1;
        mem_we_o    <= 1'b1;
        mem_addr_o  <= cur_ff;
        mem_wdata_o <= in_data_s;
      end else if (out_load) begin
        mem_req_o  <= 1'b1;
        mem_addr_o <= cur_ff;
      end
    end
  end

  // ---------------------------------------------------------------
  // peripheral input handshake
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dev_in_ack_o    <= 1'b0;
      word_in_sent_ff <= 1'b0;
    end else if (ce_i) begin
      if (st_ff == IOSQ_IDLE) word_in_sent_ff <= 1'b0;
      if (in_take || (st_ff == IOSQ_WIN && in_rdy_s && !word_in_sent_ff)) begin
        dev_in_ack_o <= 1'b1;
        if (st_ff == IOSQ_WIN) word_in_sent_ff <= 1'b1;
      end else if (!in_rdy_s) begin
        dev_in_ack_o <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // outgoing words through the fifo
  // ---------------------------------------------------------------
  always_comb begin
    push_word = '0;
    if (st_ff == IOSQ_WORD3 && ins_ff.opcode == `IOSQ_OP_SELECT) begin
      push_word = '{valid: 1'b1, is_select: 1'b1, data: w2_ff};
    end else if (st_ff == IOSQ_MWAIT && ins_ff.opcode == `IOSQ_OP_SELECT && dly_ff == 16'h0000) begin
      push_word = '{valid: 1'b1, is_select: 1'b1, data: w3_ff};
    end else if (st_ff == IOSQ_MWAIT && ins_ff.opcode == `IOSQ_OP_IMM_OUT && dly_ff == 16'h0000) begin
      push_word = '{valid: 1'b1, is_select: 1'b0, data: w2_ff};
    end else if (!blk_in && mem_rd_pend_ff && mem_ack_i) begin
      push_word = '{valid: 1'b1, is_select: 1'b0, data: mem_rdata_i};
    end
  end
  assign fifo_push = push_word.valid && fifo_in_ready;

  iosq_fifo #(.WIDTH(10), .DEPTH(`IOSQ_FIFO_DEPTH)) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .nrst_i      (nrst_i),
    .ce_i        (ce_i),
    .clr_i       (1'b0),
    .in_data_i   ({push_word.valid, push_word.is_select, push_word.data}),
    .in_valid_i  (push_word.valid),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (out_ack_s && dev_out_rdy_o)
  );
  assign dev_out_rdy_o  = fifo_out_valid;
  assign dev_out_sel_o  = fifo_out_data[8];
  assign dev_out_data_o = fifo_out_data[7:0];

  // ---------------------------------------------------------------
  // delay counter: marks pushes done and paces the timed ops
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dly_ff <= '0;
    end else if (ce_i) begin
      if (st_ff == IOSQ_WORD2 && (ins_ff.opcode == `IOSQ_OP_BUF_IN ||
                                  ins_ff.opcode == `IOSQ_OP_BUF_OUT)) begin
        dly_ff <= 16'(`IOSQ_BUF_START_CYC - 2);
      end else if (st_ff == IOSQ_FETCH && ins_ff.opcode == `IOSQ_OP_WORD_IN) begin
        dly_ff <= 16'(`IOSQ_WORD_IN_CYC - 1);
      end else if (st_ff == IOSQ_DELAY && dly_ff != 16'h0000) begin
        dly_ff <= dly_ff - 16'h0001;
      end else if (st_ff == IOSQ_MWAIT && fifo_push) begin
        dly_ff <= 16'h0001;
      end else if (st_ff == IOSQ_IDLE) begin
        dly_ff <= '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // completion, next address, accumulator, buffer controls
  // ---------------------------------------------------------------
  wire logic busy_br = is_two && ins_ff.opcode != `IOSQ_OP_IMM_OUT && buf_busy_i;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      exec_done_o     <= 1'b0;
      next_p_o        <= '0;
      acc_we_o        <= 1'b0;
      acc_o           <= `IOSQ_ACC_RST;
      buf_in_start_o  <= 1'b0;
      buf_out_start_o <= 1'b0;
      buf_clear_o     <= 1'b0;
    end else if (ce_i) begin
      exec_done_o     <= 1'b0;
      acc_we_o        <= 1'b0;
      buf_in_start_o  <= 1'b0;
      buf_out_start_o <= 1'b0;
      buf_clear_o     <= 1'b0;
      if (st_ff == IOSQ_WIN && in_rdy_s && !word_in_sent_ff) begin
        acc_o    <= in_data_s;
        acc_we_o <= 1'b1;
      end
      if (st_ff == IOSQ_XFER && blk_in && disc_s && nxt_st == IOSQ_DONE) begin
        acc_o    <= iosq_word_t'(cur_ff[7:0] + 8'h01);
        acc_we_o <= 1'b1;
      end
      if (st_ff == IOSQ_DONE) begin
        exec_done_o <= 1'b1;
        if (is_three) next_p_o <= iosq_addr_t'(p_ff + 2'd3);
        else if (busy_br) next_p_o <= join_addr(tag_val_i, w2_ff);
        else if (is_two) next_p_o <= iosq_addr_t'(p_ff + 2'd2);
        else next_p_o <= iosq_addr_t'(p_ff + 1'b1);
        if (ins_ff.opcode == `IOSQ_OP_BUF_IN && !buf_busy_i) buf_in_start_o <= 1'b1;
        if (ins_ff.opcode == `IOSQ_OP_BUF_OUT && !buf_busy_i) buf_out_start_o <= 1'b1;
        if (ins_ff.opcode == `IOSQ_OP_BUF_CLR) buf_clear_o <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_done_pulse: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    exec_done_o |=> !exec_done_o) else $error("done longer than one cycle");
  a_start_excl: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !(buf_in_start_o && buf_out_start_o)) else $error("two buffer starts");
  a_start_done: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    buf_in_start_o |-> exec_done_o) else $error("buffer start without done");
  a_clr_done: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    buf_clear_o |-> exec_done_o) else $error("clear without done");
  a_skip_bound: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    mem_req_o && st_ff == IOSQ_XFER |-> mem_addr_o[7:0] != 8'hff) else $error("boundary hit");
  a_in_ack: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    $rose(dev_in_ack_o) |-> $past(in_rdy_s)) else $error("ack without ready");
  a_acc_wr: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    acc_we_o |-> st_ff == IOSQ_DONE || st_ff == IOSQ_WIN) else $error("stray acc write");
  a_blk_next: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    exec_done_o && is_blk |-> next_p_o == iosq_addr_t'(p_ff + 2'd3)) else $error("bad p+3");
  c_blk_in:  cover property (@(posedge ref_clk_i) exec_done_o && blk_in);
  c_busy:    cover property (@(posedge ref_clk_i) exec_done_o && busy_br);
  c_word_in: cover property (@(posedge ref_clk_i) acc_we_o && ins_ff.opcode == `IOSQ_OP_WORD_IN);
endmodule

//--- testbench/iosq_periph.sv
// peripheral model on the far side of the i/o lines
`timescale 1ns/1ps
module iosq_periph
  import iosq_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire iosq_word_t out_data_i,
  input  wire logic       out_sel_i,
  input  wire logic       out_rdy_i,
  output logic            out_ack_o,
  output iosq_word_t      in_data_o,
  output logic            in_rdy_o,
  input  wire logic       in_ack_i,
  input  wire logic       disc_en_i,
  output logic            disc_o
);
  iosq_word_t in_q[$];
  logic [8:0] out_q[$];
  initial begin
    out_ack_o = 1'b0;
    in_rdy_o  = 1'b0;
    in_data_o = 8'h00;
    disc_o    = 1'b0;
  end
  // ----------------------------------------
  // output side: slow taker, one ack pulse per word
  // ----------------------------------------
  always begin
    @(negedge ref_clk_i);
    if (out_rdy_i === 1'b1) begin
      out_q.push_back({out_sel_i, out_data_i});
      out_ack_o = 1'b1;
      @(negedge ref_clk_i);
      out_ack_o = 1'b0;
      // gap lets the two-flop sync see separate pulses and fills the fifo
      repeat (6) @(negedge ref_clk_i);
    end
  end
  // ----------------------------------------
  // input side: level ready, wait ack, drop, wait ack low
  // ----------------------------------------
  always begin
    @(negedge ref_clk_i);
    disc_o = disc_en_i && (in_q.size() == 0);
    if (in_q.size() != 0) begin
      in_data_o = in_q.pop_front();
      in_rdy_o = 1'b1;
      while (in_ack_i !== 1'b1) @(negedge ref_clk_i);
      in_rdy_o = 1'b0;
      // released lines show the inverse so a late sample cannot match
      in_data_o = ~in_data_o;
      while (in_ack_i === 1'b1) @(negedge ref_clk_i);
    end
  end
endmodule

//--- testbench/tb.sv
// self-checking bench for the i/o instruction sequencer
`timescale 1ns/1ps
`include "iosq_params.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb
  import iosq_pkg::*;
;
  logic        ref_clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        exec_start_i = 1'b0;
  iosq_instr_t exec_instr_i = '0;
  iosq_addr_t  exec_p_i = '0, next_p_o, mem_addr_o, nx;
  iosq_word_t  acc_o, mem_wdata_o, dev_out_data_o, dev_in_data_i, acc_got;
  iosq_word_t  mem_rdata_i = 8'h00;
  iosq_word_t  mem [4096];
  logic [1:0]  tag_sel_o;
  logic [3:0]  tags [4] = '{4'h0, 4'h5, 4'ha, 4'h3};
  logic        exec_done_o, acc_we_o, mem_req_o, mem_we_o, buf_in_start_o, buf_out_start_o;
  logic        buf_clear_o, dev_out_sel_o, dev_out_rdy_o, dev_out_ack_i, dev_in_rdy_i;
  logic        dev_in_ack_o, dev_disc_i, we, bi, bo, bc;
  logic        mem_ack_i = 1'b0, buf_busy_i = 1'b0, disc_en = 1'b0;
  int          n_mismatch = 0, n_compared = 0, cyc, ticks = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  iosq_top iosq_top_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
    .exec_start_i(exec_start_i), .exec_instr_i(exec_instr_i), .exec_p_i(exec_p_i),
    .exec_done_o(exec_done_o), .next_p_o(next_p_o), .acc_we_o(acc_we_o), .acc_o(acc_o),
    .tag_sel_o(tag_sel_o), .tag_val_i(tags[tag_sel_o]), .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .buf_in_start_o(buf_in_start_o),
    .buf_out_start_o(buf_out_start_o), .buf_clear_o(buf_clear_o), .buf_busy_i(buf_busy_i),
    .dev_out_data_o(dev_out_data_o), .dev_out_sel_o(dev_out_sel_o),
    .dev_out_rdy_o(dev_out_rdy_o), .dev_out_ack_i(dev_out_ack_i),
    .dev_in_data_i(dev_in_data_i), .dev_in_rdy_i(dev_in_rdy_i),
    .dev_in_ack_o(dev_in_ack_o), .dev_disc_i(dev_disc_i));
  iosq_periph iosq_periph_i (.ref_clk_i(ref_clk_i), .out_data_i(dev_out_data_o),
    .out_sel_i(dev_out_sel_o), .out_rdy_i(dev_out_rdy_o), .out_ack_o(dev_out_ack_i),
    .in_data_o(dev_in_data_i), .in_rdy_o(dev_in_rdy_i), .in_ack_i(dev_in_ack_o),
    .disc_en_i(disc_en), .disc_o(dev_disc_i));
  // one word per request, ack raised on the same negedge that sees the request
  always @(negedge ref_clk_i) begin
    mem_ack_i <= 1'b0;
    if (mem_req_o === 1'b1 && !mem_ack_i) begin
      mem_ack_i <= 1'b1;
      mem_rdata_i <= mem[mem_addr_o];
      if (mem_we_o) mem[mem_addr_o] = mem_wdata_o;
    end
  end
  task automatic end_of_test;
    $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    ticks++;
    if (ticks == 20000) begin
      n_mismatch++;
      end_of_test;
    end
  end
  // ----------------------------------------
  // one instruction, pulses gathered until done
  // ----------------------------------------
  task automatic exec(input logic [5:0] op, input logic [1:0] t, input iosq_addr_t p);
    @(negedge ref_clk_i);
    exec_start_i = 1'b1;
    exec_instr_i = '{tag_sel: t, opcode: op};
    exec_p_i = p;
    {we, bi, bo, bc} = 4'h0;
    cyc = 0;
    do begin
      @(negedge ref_clk_i);
      exec_start_i = 1'b0;
      cyc++;
      if (acc_we_o === 1'b1) acc_got = acc_o;
      {we, bi, bo, bc} |= {acc_we_o, buf_in_start_o, buf_out_start_o, buf_clear_o};
    end while (exec_done_o !== 1'b1 && cyc < 3000);
    if (exec_done_o !== 1'b1) n_mismatch++;
    nx = next_p_o;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_imm_out;
    iosq_periph_i.out_q.delete();
    mem[12'h041] = 8'h5a;
    exec(`IOSQ_OP_IMM_OUT, 2'd2, 12'h040);
    repeat (20) @(negedge ref_clk_i);
    `CHK(iosq_periph_i.out_q.size(), 1)
    `CHK(iosq_periph_i.out_q[0], {1'b0, 8'h5a})
    `CHK(nx, 12'h042)
  endtask
  task automatic t_select;
    iosq_periph_i.out_q.delete();
    mem[12'h061] = 8'h2a;
    mem[12'h062] = 8'h15;
    exec(`IOSQ_OP_SELECT, 2'd0, 12'h060);
    repeat (30) @(negedge ref_clk_i);
    `CHK(iosq_periph_i.out_q[0], {1'b1, 8'h2a})
    `CHK(iosq_periph_i.out_q[1], {1'b1, 8'h15})
    `CHK(nx, 12'h063)
  endtask
  task automatic t_blk_out;
    // five words through a four-deep fifo against a slow taker, over the 0xff gap
    iosq_addr_t a [5] = '{12'h5fd, 12'h5fe, 12'h500, 12'h501, 12'h502};
    iosq_periph_i.out_q.delete();
    mem[12'h101] = 8'hfd;
    mem[12'h102] = 8'h03;
    mem[12'h5ff] = 8'hee;
    foreach (a[i]) mem[a[i]] = 8'ha0 + 8'(i);
    exec(`IOSQ_OP_BLK_OUT, 2'd1, 12'h100);
    repeat (60) @(negedge ref_clk_i);
    `CHK(iosq_periph_i.out_q.size(), 5)
    foreach (a[i]) `CHK(iosq_periph_i.out_q[i], {1'b0, 8'ha0 + 8'(i)})
    `CHK(nx, 12'h103)
  endtask
  task automatic t_blk_in;
    // three words over the 0xff gap, ended by a disconnect before the end address
    iosq_addr_t a [3] = '{12'hafe, 12'ha00, 12'ha01};
    mem[12'h201] = 8'hfe;
    mem[12'h202] = 8'h10;
    mem[12'haff] = 8'hee;
    iosq_periph_i.in_q = '{8'h11, 8'h22, 8'h33};
    disc_en = 1'b1;
    exec(`IOSQ_OP_BLK_IN, 2'd2, 12'h200);
    disc_en = 1'b0;
    foreach (a[i]) `CHK(mem[a[i]], 8'h11 * 8'(i + 1))
    `CHK(mem[12'haff], 8'hee)
    `CHK({we, acc_got}, {1'b1, 8'h03})
    `CHK(nx, 12'h203)
    repeat (6) @(negedge ref_clk_i);
  endtask
  task automatic t_word_in;
    iosq_periph_i.in_q = '{8'hc3};
    exec(`IOSQ_OP_WORD_IN, 2'd3, 12'h300);
    `CHK({we, acc_got}, {1'b1, 8'hc3})
    `CHK(nx, 12'h301)
    `CHK(cyc >= `IOSQ_WORD_IN_CYC, 1'b1)
  endtask
  task automatic t_buf_start;
    mem[12'h401] = 8'h44;
    for (int k = 0; k < 4; k++) begin
      buf_busy_i = k[1];
      exec(k[0] ? `IOSQ_OP_BUF_OUT : `IOSQ_OP_BUF_IN, 2'd3, 12'h400);
      `CHK(nx, k[1] ? 12'h344 : 12'h402)
      `CHK({bi, bo}, k[1] ? 2'b00 : (k[0] ? 2'b01 : 2'b10))
      `CHK(cyc >= `IOSQ_BUF_START_CYC, 1'b1)
    end
    buf_busy_i = 1'b0;
  endtask
  task automatic t_buf_clr;
    exec(`IOSQ_OP_BUF_CLR, 2'd1, 12'h500);
    `CHK({bc, nx}, {1'b1, 12'h501})
  endtask
  initial begin
    repeat (4) @(negedge ref_clk_i);
    nrst_i = 1'b1;
    t_imm_out();
    t_select();
    t_blk_out();
    t_blk_in();
    t_word_in();
    t_buf_start();
    t_buf_clr();
    end_of_test();
  end
endmodule
